// [verilog/slip_buffer_mode_control.sv]
// slip buffer mode control, signaling freeze and register slave
`timescale 1ns/1ps
`default_nettype none
module slip_buffer_mode_control (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clkEn,
    input wire slip_ctl_pkg::axi_req_t axiReq,
    output slip_ctl_pkg::axi_rsp_t axiRsp,
    input wire logic rx_serial_clock_pin,
    input wire logic rxSlipDetect,
    input wire logic rxMultiframeStart,
    input wire logic rxSigValid,
    input wire slip_ctl_pkg::sig_update_t rxSigUpdate,
    output logic txBufferFifo,
    output slip_ctl_pkg::rx_mode_t rxBufferMode,
    output logic [4:0] fifoLatency,
    output logic rxSerClkOe,
    output logic rxSyncOe,
    output slip_ctl_pkg::sig_update_t rxSigOut,
    output logic rxSigOutValid
);
    import slip_ctl_pkg::*;

    typedef struct packed {
        logic slipTgl;
        logic mfTgl;
        logic updTgl;
        sig_update_t upd;
    } link_state_t;

    typedef struct packed {
        logic txFifoSel;
        logic forceHold;
        logic holdOnSlip;
        logic syncDir;
        rx_mode_t rxMode;
        logic [4:0] latency;
        logic slipHold;
        logic [1:0] mfCount;
        logic [2:0] slipSync;
        logic [2:0] mfSync;
        logic [2:0] updSync;
        logic [31:0][3:0] sigArray;
        sig_update_t sigOut;
        logic sigOutValid;
        logic serClkOe;
        logic syncOe;
        logic awHave;
        logic [11:0] awIdx;
        logic wHave;
        logic [7:0] wData;
        logic wStrb0;
        axi_rsp_t rsp;
    } state_t;

    logic [1:0] rstPipe;
    logic rstN;
    logic [1:0] linkRstPipe;
    logic linkRstN;
    link_state_t lk_reg;
    link_state_t lk_next;
    state_t st_reg;
    state_t st_next;
    logic slipEdge;
    logic mfEdge;
    logic updEdge;
    logic frozen;
    logic writeFire;

    function automatic logic [11:0] wordIndex(input logic [15:0] addr);
        wordIndex = addr[13:2];
    endfunction

    function automatic logic isBypass(input rx_mode_t mode);
        isBypass = (mode == MODE_BYPASS) || (mode == MODE_BYPASS_ALT);
    endfunction

    function automatic logic isMapped(input logic [11:0] idx);
        isMapped = (idx == IDX_SLIP_CTRL) || (idx == IDX_LATENCY)
            || ((idx >= IDX_SIG_FIRST) && (idx <= IDX_SIG_LAST));
    endfunction

    // reset release in each domain
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstN = rstPipe[1];

    always_ff @(posedge rx_serial_clock_pin or negedge nrst) begin
        if (!nrst) begin
            linkRstPipe <= 2'h0;
        end else begin
            linkRstPipe <= {linkRstPipe[0], 1'b1};
        end
    end
    assign linkRstN = linkRstPipe[1];

    // link side: events become toggles, update word held until the next one
    always_comb begin
        lk_next = lk_reg;
        if (rxSlipDetect) begin
            lk_next.slipTgl = ~lk_reg.slipTgl;
        end
        if (rxMultiframeStart) begin
            lk_next.mfTgl = ~lk_reg.mfTgl;
        end
        if (rxSigValid) begin
            lk_next.updTgl = ~lk_reg.updTgl;
            lk_next.upd = rxSigUpdate;
        end
    end

    always_ff @(posedge rx_serial_clock_pin or negedge linkRstN) begin
        if (!linkRstN) begin
            lk_reg <= '0;
        end else begin
            lk_reg <= lk_next;
        end
    end

    // system side edges, taken after the two synchroniser flops
    assign slipEdge = st_reg.slipSync[2] ^ st_reg.slipSync[1];
    assign mfEdge = st_reg.mfSync[2] ^ st_reg.mfSync[1];
    assign updEdge = st_reg.updSync[2] ^ st_reg.updSync[1];
    assign frozen = st_reg.forceHold || st_reg.slipHold || (slipEdge && st_reg.holdOnSlip);
    assign writeFire = st_reg.awHave && st_reg.wHave && !st_reg.rsp.bvalid;

    always_comb begin
        st_next = st_reg;
        st_next.slipSync = {st_reg.slipSync[1:0], lk_reg.slipTgl};
        st_next.mfSync = {st_reg.mfSync[1:0], lk_reg.mfTgl};
        st_next.updSync = {st_reg.updSync[1:0], lk_reg.updTgl};
        st_next.sigOutValid = 1'b0;
        // two boundaries after a slip cover at least one whole multiframe
        if (mfEdge && st_reg.slipHold) begin
            if (st_reg.mfCount == MF_HOLD_COUNT - 2'h1) begin
                st_next.slipHold = 1'b0;
                st_next.mfCount = 2'h0;
            end else begin
                st_next.mfCount = st_reg.mfCount + 2'h1;
            end
        end
        if (slipEdge && st_reg.holdOnSlip) begin
            st_next.slipHold = 1'b1;
            st_next.mfCount = 2'h0;
        end
        // signaling pin and array only move while not frozen
        if (updEdge && !frozen) begin
            st_next.sigArray[lk_reg.upd.channel] = lk_reg.upd.value;
            st_next.sigOut = lk_reg.upd;
            st_next.sigOutValid = 1'b1;
        end
        // write address and data, taken in either order
        if (axiReq.awvalid && st_reg.rsp.awready) begin
            st_next.awHave = 1'b1;
            st_next.awIdx = wordIndex(axiReq.awaddr);
        end
        if (axiReq.wvalid && st_reg.rsp.wready) begin
            st_next.wHave = 1'b1;
            st_next.wData = axiReq.wdata[7:0];
            st_next.wStrb0 = axiReq.wstrb[0];
        end
        if (st_reg.rsp.bvalid && axiReq.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        if (writeFire) begin
            st_next.awHave = 1'b0;
            st_next.wHave = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = RESP_OKAY;
            if (st_reg.awIdx == IDX_SLIP_CTRL) begin
                if (st_reg.wStrb0) begin
                    // bits 6 and 5 are dropped
                    st_next.txFifoSel = st_reg.wData[BIT_TX_FIFO];
                    st_next.forceHold = st_reg.wData[BIT_FORCE_HOLD];
                    st_next.holdOnSlip = st_reg.wData[BIT_SLIP_HOLD];
                    st_next.syncDir = st_reg.wData[BIT_SYNC_DIR];
                    st_next.rxMode = rx_mode_t'(st_reg.wData[BIT_MODE_LO +: 2]);
                end
            end else if (st_reg.awIdx == IDX_LATENCY) begin
                if (st_reg.wStrb0) begin
                    st_next.latency = st_reg.wData[4:0];
                end
            end else begin
                st_next.rsp.bresp = RESP_SLVERR;
            end
        end
        // read channel
        if (st_reg.rsp.rvalid && axiReq.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && st_reg.rsp.arready) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata = 32'h0000_0000;
            st_next.rsp.rresp = RESP_OKAY;
            if (wordIndex(axiReq.araddr) == IDX_SLIP_CTRL) begin
                st_next.rsp.rdata[BIT_TX_FIFO] = st_reg.txFifoSel;
                st_next.rsp.rdata[BIT_FORCE_HOLD] = st_reg.forceHold;
                st_next.rsp.rdata[BIT_SLIP_HOLD] = st_reg.holdOnSlip;
                st_next.rsp.rdata[BIT_SYNC_DIR] = st_reg.syncDir;
                st_next.rsp.rdata[BIT_MODE_LO +: 2] = st_reg.rxMode;
            end else if (wordIndex(axiReq.araddr) == IDX_LATENCY) begin
                st_next.rsp.rdata[4:0] = st_reg.latency;
            end else if (isMapped(wordIndex(axiReq.araddr))) begin
                st_next.rsp.rdata[3:0] = st_reg.sigArray[axiReq.araddr[6:2]];
            end else begin
                st_next.rsp.rresp = RESP_SLVERR;
            end
        end
        st_next.rsp.awready = !st_next.awHave && !st_next.rsp.bvalid;
        st_next.rsp.wready = !st_next.wHave && !st_next.rsp.bvalid;
        st_next.rsp.arready = !st_next.rsp.rvalid;
        // pin directions from mode and sync direction
        st_next.serClkOe = isBypass(st_next.rxMode);
        st_next.syncOe = isBypass(st_next.rxMode) || !st_next.syncDir;
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            st_reg <= '0;
            st_reg.txFifoSel <= RST_TX_FIFO;
            st_reg.forceHold <= RST_FORCE_HOLD;
            st_reg.holdOnSlip <= RST_SLIP_HOLD;
            st_reg.syncDir <= RST_SYNC_DIR;
            st_reg.rxMode <= rx_mode_t'(RST_RX_MODE);
            st_reg.latency <= RST_LATENCY;
            st_reg.serClkOe <= 1'b1;
            st_reg.syncOe <= 1'b1;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    assign axiRsp = st_reg.rsp;
    assign txBufferFifo = st_reg.txFifoSel;
    assign rxBufferMode = st_reg.rxMode;
    assign fifoLatency = st_reg.latency;
    assign rxSerClkOe = st_reg.serClkOe;
    assign rxSyncOe = st_reg.syncOe;
    assign rxSigOut = st_reg.sigOut;
    assign rxSigOutValid = st_reg.sigOutValid;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstN);

    a_tx_mode_write: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_SLIP_CTRL && st_reg.wStrb0)
        |=> txBufferFifo == $past(st_reg.wData[BIT_TX_FIFO]))
        else $error("tx buffer mode not taken from control write");

    a_latency_write: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_LATENCY && st_reg.wStrb0)
        |=> fifoLatency == $past(st_reg.wData[4:0]))
        else $error("latency not taken from latency write");

    a_force_hold_pins: assert property (
        st_reg.forceHold |=> $stable(rxSigOut) && !rxSigOutValid && $stable(st_reg.sigArray))
        else $error("signaling moved while force hold set");

    a_slip_starts_hold: assert property (
        (clkEn && slipEdge && st_reg.holdOnSlip) |=> st_reg.slipHold ##1 !rxSigOutValid)
        else $error("slip did not start signaling hold");

    a_slip_hold_ends: assert property (
        $fell(st_reg.slipHold) |-> $past(mfEdge) && $past(st_reg.mfCount) == 2'h1)
        else $error("slip hold ended before a full multiframe");

    a_bypass_pins_out: assert property (
        isBypass(st_reg.rxMode) |-> rxSerClkOe && rxSyncOe)
        else $error("bypass mode must drive clock and sync");

    a_buffer_sync_dir: assert property (
        !isBypass(st_reg.rxMode) |-> !rxSerClkOe && (rxSyncOe == !st_reg.syncDir))
        else $error("buffered mode pin directions wrong");

    a_reserved_read_zero: assert property (
        (clkEn && axiReq.arvalid && axiRsp.arready
            && wordIndex(axiReq.araddr) == IDX_SLIP_CTRL)
        |=> axiRsp.rvalid && axiRsp.rdata[6:5] == 2'h0 && axiRsp.rdata[31:8] == 24'h00_0000)
        else $error("reserved control bits read nonzero");

    a_mode_write: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_SLIP_CTRL && st_reg.wStrb0)
        |=> rxBufferMode == rx_mode_t'($past(st_reg.wData[BIT_MODE_LO +: 2])))
        else $error("receive buffer mode not taken from control write");

    a_hold_bits_write: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_SLIP_CTRL && st_reg.wStrb0)
        |=> st_reg.forceHold == $past(st_reg.wData[BIT_FORCE_HOLD])
            && st_reg.holdOnSlip == $past(st_reg.wData[BIT_SLIP_HOLD])
            && st_reg.syncDir == $past(st_reg.wData[BIT_SYNC_DIR]))
        else $error("hold or sync bits not taken from control write");

    a_slip_mode_pins: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_SLIP_CTRL && st_reg.wStrb0
            && st_reg.wData[BIT_MODE_LO +: 2] == MODE_SLIP)
        |=> !rxSerClkOe && rxSyncOe == !$past(st_reg.wData[BIT_SYNC_DIR]))
        else $error("slip buffer mode pin directions wrong");

    a_fifo_mode_pins: assert property (
        (clkEn && writeFire && st_reg.awIdx == IDX_SLIP_CTRL && st_reg.wStrb0
            && st_reg.wData[BIT_MODE_LO +: 2] == MODE_FIFO)
        |=> !rxSerClkOe && rxSyncOe == !$past(st_reg.wData[BIT_SYNC_DIR]))
        else $error("fifo mode pin directions wrong");

    a_update_passes: assert property (
        (clkEn && updEdge && !frozen)
        |=> rxSigOutValid && rxSigOut == $past(lk_reg.upd))
        else $error("signaling update not passed while free");

    a_slip_hold_blocks: assert property (
        st_reg.slipHold |=> !rxSigOutValid && $stable(st_reg.sigArray))
        else $error("signaling moved during slip hold");

    a_array_write_refused: assert property (
        (clkEn && writeFire && st_reg.awIdx >= IDX_SIG_FIRST
            && st_reg.awIdx <= IDX_SIG_LAST)
        |=> axiRsp.bvalid && axiRsp.bresp == RESP_SLVERR)
        else $error("signaling array write not refused");

    a_latency_read: assert property (
        (clkEn && axiReq.arvalid && axiRsp.arready
            && wordIndex(axiReq.araddr) == IDX_LATENCY)
        |=> axiRsp.rvalid && axiRsp.rdata == {27'h000_0000, $past(st_reg.latency)})
        else $error("latency read value wrong");

    a_control_read: assert property (
        (clkEn && axiReq.arvalid && axiRsp.arready
            && wordIndex(axiReq.araddr) == IDX_SLIP_CTRL)
        |=> axiRsp.rdata[BIT_TX_FIFO] == $past(txBufferFifo)
            && axiRsp.rdata[BIT_SYNC_DIR] == $past(st_reg.syncDir))
        else $error("control read value wrong");

    c_slip_hold: cover property (slipEdge && st_reg.holdOnSlip ##[1:400] $fell(st_reg.slipHold));
    c_force_hold: cover property (st_reg.forceHold && updEdge);
    c_fifo_mode: cover property (st_reg.rxMode == MODE_FIFO && !st_reg.syncDir);
    c_sig_update: cover property (rxSigOutValid);
    c_slip_mode: cover property (st_reg.rxMode == MODE_SLIP && st_reg.syncDir);
endmodule
`default_nettype wire

// [verilog/slip_ctl_pkg.sv]
// constants, types and carriers for the slip buffer mode control block
package slip_ctl_pkg;
    localparam logic [11:0] IDX_SLIP_CTRL = 12'h0116;
    localparam logic [11:0] IDX_LATENCY = 12'h0117;
    localparam logic [11:0] IDX_SIG_FIRST = 12'h0500;
    localparam logic [11:0] IDX_SIG_LAST = 12'h051F;
    localparam int BIT_TX_FIFO = 7;
    localparam int BIT_FORCE_HOLD = 4;
    localparam int BIT_SLIP_HOLD = 3;
    localparam int BIT_SYNC_DIR = 2;
    localparam int BIT_MODE_LO = 0;
    localparam logic RST_TX_FIFO = 1'b0;
    localparam logic RST_FORCE_HOLD = 1'b0;
    localparam logic RST_SLIP_HOLD = 1'b0;
    localparam logic RST_SYNC_DIR = 1'b1;
    localparam logic [1:0] RST_RX_MODE = 2'h3;
    localparam logic [4:0] RST_LATENCY = 5'h04;
    localparam logic [1:0] MF_HOLD_COUNT = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_BYPASS = 2'b00,
        MODE_SLIP = 2'b01,
        MODE_FIFO = 2'b10,
        MODE_BYPASS_ALT = 2'b11
    } rx_mode_t;

    typedef struct packed {
        logic awvalid;
        logic [15:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [15:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic [4:0] channel;
        logic [3:0] value;
    } sig_update_t;
endpackage

// [verification/backplane_model.sv]
// backplane model: receive serial clock and receive event pulses
`timescale 1ns/1ps
`default_nettype none
module backplane_model (
    output var logic rx_serial_clock_pin,
    output var logic rxSlipDetect,
    output var logic rxMultiframeStart,
    output var logic rxSigValid,
    output var slip_ctl_pkg::sig_update_t rxSigUpdate
);
    import slip_ctl_pkg::*;
    initial begin
        rx_serial_clock_pin = 1'b0;
        rxSlipDetect = 1'b0;
        rxMultiframeStart = 1'b0;
        rxSigValid = 1'b0;
        rxSigUpdate = '0;
        #3.7;
        forever #16 rx_serial_clock_pin = ~rx_serial_clock_pin;
    end
    // transmit clock and multiframe sync would share this one clock source
    // slip or multiframe pulse, launched on serial clock edges
    task automatic pulse(input logic slip);
        @(posedge rx_serial_clock_pin);
        rxSlipDetect <= slip;
        rxMultiframeStart <= ~slip;
        @(posedge rx_serial_clock_pin);
        rxSlipDetect <= 1'b0;
        rxMultiframeStart <= 1'b0;
    endtask
    // one signaling word, then spacing and a bitwise inverted idle word
    task automatic sendSig(input logic [4:0] ch, input logic [3:0] val);
        @(posedge rx_serial_clock_pin);
        rxSigValid <= 1'b1;
        rxSigUpdate <= '{channel: ch, value: val};
        @(posedge rx_serial_clock_pin);
        rxSigValid <= 1'b0;
        repeat (2) @(posedge rx_serial_clock_pin);
        rxSigUpdate <= sig_update_t'(~rxSigUpdate);
    endtask
endmodule
`default_nettype wire

// [verification/slip_buffer_mode_control_bench.sv]
// self-checking bench for the slip buffer mode control block
`timescale 1ns/1ps
`default_nettype none
module slip_buffer_mode_control_bench;
    import slip_ctl_pkg::*;
    logic clk_sys;
    logic nrst;
    logic clkEn;
    axi_req_t axiReq;
    axi_rsp_t axiRsp;
    logic rx_serial_clock_pin;
    logic rxSlipDetect;
    logic rxMultiframeStart;
    logic rxSigValid;
    sig_update_t rxSigUpdate;
    logic txBufferFifo;
    rx_mode_t rxBufferMode;
    logic [4:0] fifoLatency;
    logic rxSerClkOe;
    logic rxSyncOe;
    sig_update_t rxSigOut;
    logic rxSigOutValid;
    int error_cnt;
    int checked;

    slip_buffer_mode_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn),
        .axiReq(axiReq), .axiRsp(axiRsp), .rx_serial_clock_pin(rx_serial_clock_pin), .rxSlipDetect(rxSlipDetect),
        .rxMultiframeStart(rxMultiframeStart), .rxSigValid(rxSigValid),
        .rxSigUpdate(rxSigUpdate), .txBufferFifo(txBufferFifo), .rxBufferMode(rxBufferMode),
        .fifoLatency(fifoLatency), .rxSerClkOe(rxSerClkOe), .rxSyncOe(rxSyncOe),
        .rxSigOut(rxSigOut), .rxSigOutValid(rxSigOutValid));
    backplane_model u_far (.rx_serial_clock_pin(rx_serial_clock_pin), .rxSlipDetect(rxSlipDetect),
        .rxMultiframeStart(rxMultiframeStart), .rxSigValid(rxSigValid),
        .rxSigUpdate(rxSigUpdate));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask

    task automatic tick(inout int n);
        @(posedge clk_sys);
        n++;
        if (n > 500) begin
            $display("BAD bus wait expected %0d seen %0d", 500, n);
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic wr(input string name, input logic [11:0] idx, input logic [7:0] v,
                      input logic [1:0] er);
        int n;
        logic aw;
        logic w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        axiReq.awaddr <= {2'b00, idx, 2'b00};
        axiReq.wdata <= {24'h00_0000, v};
        axiReq.wstrb <= 4'hF;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        while (!(aw && w)) begin
            tick(n);
            if (!aw && axiRsp.awready === 1'b1) begin
                aw = 1'b1;
                axiReq.awvalid <= 1'b0;
            end
            if (!w && axiRsp.wready === 1'b1) begin
                w = 1'b1;
                axiReq.wvalid <= 1'b0;
            end
        end
        do tick(n); while (axiRsp.bvalid !== 1'b1);
        chk(name, 32'(er), 32'(axiRsp.bresp));
    endtask

    task automatic rd(input string name, input logic [11:0] idx, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        axiReq.araddr <= {2'b00, idx, 2'b00};
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do tick(n); while (axiRsp.arready !== 1'b1);
        axiReq.arvalid <= 1'b0;
        do tick(n); while (axiRsp.rvalid !== 1'b1);
        chk(name, e, axiRsp.rdata);
        chk(name, 32'(er), 32'(axiRsp.rresp));
    endtask

    task automatic sigExpect(input logic [4:0] ch, input logic [3:0] v, input logic pass);
        logic seen;
        sig_update_t got;
        seen = 1'b0;
        got = '0;
        fork
            u_far.sendSig(ch, v);
            for (int i = 0; i < 60; i++) begin
                @(posedge clk_sys);
                if (rxSigOutValid === 1'b1) begin
                    seen = 1'b1;
                    got = rxSigOut;
                end
            end
        join
        chk("rxSigOutValid", 32'(pass), 32'(seen));
        if (pass) begin
            chk("rxSigOut", 32'({ch, v}), 32'(got));
        end
    endtask

    task automatic checkReset();
        chk("txBufferFifo", 32'h0, 32'(txBufferFifo));
        chk("rxBufferMode", 32'h3, 32'(rxBufferMode));
        chk("rxSerClkOe", 32'h1, 32'(rxSerClkOe));
        chk("rxSyncOe", 32'h1, 32'(rxSyncOe));
        chk("fifoLatency", 32'h4, 32'(fifoLatency));
        rd("control reset", IDX_SLIP_CTRL, 32'h0000_0007, RESP_OKAY);
        rd("latency reset", IDX_LATENCY, 32'h0000_0004, RESP_OKAY);
    endtask

    task automatic checkModes();
        logic [1:0] m;
        logic d;
        logic byp;
        for (int i = 0; i < 8; i++) begin
            m = i[1:0];
            d = i[2];
            byp = (m == 2'b00) || (m == 2'b11);
            wr("control write", IDX_SLIP_CTRL, {d, 2'b11, 2'b00, d, m}, RESP_OKAY);
            rd("control read", IDX_SLIP_CTRL, 32'({d, 4'h0, d, m}), RESP_OKAY);
            chk("txBufferFifo", 32'(d), 32'(txBufferFifo));
            chk("rxBufferMode", 32'(m), 32'(rxBufferMode));
            chk("rxSerClkOe", 32'(byp), 32'(rxSerClkOe));
            chk("rxSyncOe", 32'(byp || !d), 32'(rxSyncOe));
        end
    endtask

    task automatic checkRegisters();
        wr("latency write", IDX_LATENCY, 8'h1F, RESP_OKAY);
        rd("latency read", IDX_LATENCY, 32'h0000_001F, RESP_OKAY);
        chk("fifoLatency", 32'h0000_001F, 32'(fifoLatency));
        rd("unmapped read", 12'h0118, 32'h0, RESP_SLVERR);
        wr("array write", IDX_SIG_FIRST, 8'h05, RESP_SLVERR);
    endtask

    task automatic checkForceHold();
        wr("control write", IDX_SLIP_CTRL, 8'h03, RESP_OKAY);
        sigExpect(5'h03, 4'h5, 1'b1);
        rd("array entry", IDX_SIG_FIRST + 12'h003, 32'h5, RESP_OKAY);
        wr("control write", IDX_SLIP_CTRL, 8'h13, RESP_OKAY);
        sigExpect(5'h03, 4'hA, 1'b0);
        rd("array held", IDX_SIG_FIRST + 12'h003, 32'h5, RESP_OKAY);
        wr("control write", IDX_SLIP_CTRL, 8'h03, RESP_OKAY);
        sigExpect(5'h1F, 4'h6, 1'b1);
        rd("array last", IDX_SIG_LAST, 32'h6, RESP_OKAY);
    endtask

    task automatic checkSlipHold();
        u_far.pulse(1'b1);
        sigExpect(5'h02, 4'h3, 1'b1);
        wr("control write", IDX_SLIP_CTRL, 8'h0D, RESP_OKAY);
        u_far.pulse(1'b1);
        sigExpect(5'h01, 4'h9, 1'b0);
        u_far.pulse(1'b0);
        sigExpect(5'h01, 4'h9, 1'b0);
        u_far.pulse(1'b0);
        repeat (20) @(posedge clk_sys);
        sigExpect(5'h01, 4'hC, 1'b1);
        rd("array after hold", IDX_SIG_FIRST + 12'h001, 32'hC, RESP_OKAY);
    endtask

    task automatic checkClockEnable();
        clkEn <= 1'b0;
        sigExpect(5'h04, 4'h7, 1'b0);
        clkEn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk("rxSigOut", 32'({5'h04, 4'h7}), 32'(rxSigOut));
        rd("array after enable", IDX_SIG_FIRST + 12'h004, 32'h7, RESP_OKAY);
    endtask

    initial begin
        nrst = 1'b0;
        clkEn = 1'b1;
        axiReq = '0;
        error_cnt = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        checkReset();
        checkModes();
        checkRegisters();
        checkForceHold();
        checkSlipHold();
        checkClockEnable();
        report_and_stop();
    end
endmodule
`default_nettype wire
